// ==== verilog/wec_params.svh ====
// constants for the pause, examine and drive-current command block
`ifndef WEC_PARAMS_SVH
`define WEC_PARAMS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define WEC_CLK_HZ 10000000
`define WEC_MS_TIME 1
`define WEC_MS_CYCLES ((`WEC_CLK_HZ / 1000) * `WEC_MS_TIME)
`define WEC_PAUSE_UNIT_MS 10
`define WEC_PAUSE_CYCLES (`WEC_MS_CYCLES * `WEC_PAUSE_UNIT_MS)
`define WEC_PAUSE_MAX 16'hFDE8

// ----------------------------------------------------------------
// drive current
// ----------------------------------------------------------------
`define WEC_PCT_MAX 7'h64
`define WEC_HOLD_DEF 7'h19
`define WEC_RUN_DEF 7'h32

// ----------------------------------------------------------------
// register offsets and fields
// ----------------------------------------------------------------
`define WEC_OFS_STATUS 8'h00
`define WEC_OFS_CURRENT 8'h04
`define WEC_OFS_PAUSE 8'h08
`define WEC_OFS_SETTLE 8'h0C
`define WEC_OFS_PARAM 8'h40
`define WEC_OFS_PARAM_END 8'h6C
`define WEC_CUR_HOLD_LSB 0
`define WEC_CUR_RUN_LSB 8
`define WEC_ST_PCT_LSB 8

// ----------------------------------------------------------------
// parameter listing
// ----------------------------------------------------------------
`define WEC_NPARAM 12
`define WEC_IDX_CURRENT 4'h4
`define WEC_IDX_SETTLE 5
`define WEC_PARAM_RST 32'h0000_0000

// command letters (ascii)
`define WEC_LTR_PAUSE 8'h57
`define WEC_LTR_EXAM 8'h58
`define WEC_LTR_CUR 8'h59

`endif

// ==== verilog/wec_pkg.sv ====
// types of the pause, examine and drive-current command block
package wec_pkg;

  // interpreter states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WMOT = 2'b01,
    ST_WTIME = 2'b10,
    ST_DUMP = 2'b11
  } wec_state_t;

  // one parsed command from the serial front end
  typedef struct packed {
    logic [7:0] letter;
    logic has_d1;
    logic has_d2;
    logic [15:0] d1;
    logic [15:0] d2;
  } wec_cmd_t;

  // one item of a reply to the host
  typedef struct packed {
    logic [7:0] letter;
    logic two;
    logic [15:0] val_a;
    logic [15:0] val_b;
  } wec_rpt_t;

endpackage

// ==== verilog/wec_core.sv ====
// pause, parameter listing and drive-current command logic
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`include "wec_params.svh"

module wec_core
  import wec_pkg::*;
#(
  parameter int MS_CYCLES = `WEC_MS_CYCLES,
  parameter int PAUSE_CYCLES = `WEC_PAUSE_CYCLES
)
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic PROG_MODE_I,
  input wire logic MULTI_AXIS_I,
  input wire logic CMD_VALID_I,
  input wire wec_cmd_t CMD_I,
  output logic CMD_READY_O,
  input wire logic MOTION_BUSY_I,
  input wire logic CONST_MOVE_I,
  input wire logic AT_SPEED_I,
  output logic RPT_VALID_O,
  output wec_rpt_t RPT_O,
  input wire logic RPT_READY_I,
  output logic [6:0] DRIVE_PCT_O,
  output logic DRIVE_ON_O,
  output logic RUN_PHASE_O
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  wec_state_t state_reg;
  wec_state_t state_next;
  logic cmd_ready_reg;
  logic cmd_take;
  logic is_pause;
  logic is_exam;
  logic is_cur;
  logic [16:0] ms_cnt_reg;
  logic ms_tick_reg;
  logic [16:0] pre_cnt_reg;
  logic [15:0] pause_cnt_reg;
  logic [15:0] settle_cnt_reg;
  logic run_phase_reg;
  logic [6:0] hold_reg;
  logic [6:0] run_reg;
  logic [6:0] drive_pct_reg;
  logic drive_on_reg;
  logic [31:0] prm_reg [0:`WEC_NPARAM-1];
  logic [3:0] dump_idx_reg;
  logic dump_one_reg;
  logic rpt_valid_reg;
  wec_rpt_t rpt_reg;
  logic [31:0] rdata_reg;
  logic motion_done;
  logic pause_tick;
  logic cur_wr;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // percentage check shared by the command and the register path
  function automatic logic [6:0] pct_or_def(input logic ok, input logic [15:0] v,
                                            input logic [6:0] def);
    if (ok && v <= {9'h000, `WEC_PCT_MAX})
      pct_or_def = v[6:0];
    else
      pct_or_def = def;
  endfunction

  // listing letters in their fixed order
  function automatic logic [7:0] dump_letter(input logic [3:0] idx);
    case (idx)
      4'h0: dump_letter = 8'h4B;
      4'h1: dump_letter = 8'h49;
      4'h2: dump_letter = 8'h42;
      4'h3: dump_letter = 8'h56;
      4'h4: dump_letter = `WEC_LTR_CUR;
      4'h5: dump_letter = 8'h45;
      4'h6: dump_letter = 8'h44;
      4'h7: dump_letter = 8'h48;
      4'h8: dump_letter = 8'h55;
      4'h9: dump_letter = 8'h54;
      4'hA: dump_letter = 8'h31;
      default: dump_letter = 8'h4E;
    endcase
  endfunction

  // one reply item; the current entry always shows the live settings
  function automatic wec_rpt_t dump_item(input logic [3:0] idx);
    wec_rpt_t r;
    r.letter = dump_letter(idx);
    if (idx == `WEC_IDX_CURRENT)
    begin
      r.two = 1'b1;
      r.val_a = {9'h000, hold_reg};
      r.val_b = {9'h000, run_reg};
    end
    else
    begin
      r.two = (idx <= 4'h3);
      r.val_a = prm_reg[idx][15:0];
      r.val_b = prm_reg[idx][31:16];
    end
    dump_item = r;
  endfunction

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  assign cmd_take = CMD_VALID_I && cmd_ready_reg;
  assign is_pause = cmd_take && (CMD_I.letter == `WEC_LTR_PAUSE) && PROG_MODE_I;
  assign is_exam = cmd_take && (CMD_I.letter == `WEC_LTR_EXAM);
  assign is_cur = cmd_take && (CMD_I.letter == `WEC_LTR_CUR);
  assign cur_wr = WR_I && (ADDR_I == `WEC_OFS_CURRENT);

  // a constant-velocity move counts as done once it reaches speed
  assign motion_done = CONST_MOVE_I ? (AT_SPEED_I || !MOTION_BUSY_I)
                                    : !MOTION_BUSY_I;
  assign pause_tick = (pre_cnt_reg == 17'(PAUSE_CYCLES - 1));

  // ----------------------------------------------------------------
  // interpreter state machine
  // ----------------------------------------------------------------
  // next state; timed pause looks at the clock only, never at motion
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (is_pause)
        begin
          if (CMD_I.has_d1 && CMD_I.d1 != 16'h0000)
            state_next = ST_WTIME;
          else
            state_next = ST_WMOT;
        end
        else if (is_exam && !MULTI_AXIS_I && !PROG_MODE_I)
          state_next = ST_DUMP;
        else if (is_cur && !CMD_I.has_d1 && !PROG_MODE_I)
          state_next = ST_DUMP;
      end
      ST_WMOT:
        if (motion_done)
          state_next = ST_IDLE;
      ST_WTIME:
        if (pause_tick && pause_cnt_reg == 16'h0001)
          state_next = ST_IDLE;
      ST_DUMP:
        if (RPT_READY_I && (dump_one_reg || dump_idx_reg == 4'(`WEC_NPARAM - 1)))
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  // state and command acceptance; ready is low while any stall lasts
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state_reg <= ST_IDLE;
      cmd_ready_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      cmd_ready_reg <= (state_next == ST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // time bases
  // ----------------------------------------------------------------
  // free running millisecond tick for the settle delay
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ms_cnt_reg <= 17'h00000;
      ms_tick_reg <= 1'b0;
    end
    else if (ms_cnt_reg == 17'(MS_CYCLES - 1))
    begin
      ms_cnt_reg <= 17'h00000;
      ms_tick_reg <= 1'b1;
    end
    else
    begin
      ms_cnt_reg <= ms_cnt_reg + 17'h00001;
      ms_tick_reg <= 1'b0;
    end
  end

  // pause prescaler restarts at the command so each unit is a full 10 ms
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      pre_cnt_reg <= 17'h00000;
    else if (state_reg != ST_WTIME || pause_tick)
      pre_cnt_reg <= 17'h00000;
    else
      pre_cnt_reg <= pre_cnt_reg + 17'h00001;
  end

  // pause down-counter, loaded straight from the argument
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      pause_cnt_reg <= 16'h0000;
    else if (state_reg == ST_IDLE && state_next == ST_WTIME)
    begin
      // values past the top are clamped rather than wrapped
      if (CMD_I.d1 > `WEC_PAUSE_MAX)
        pause_cnt_reg <= `WEC_PAUSE_MAX;
      else
        pause_cnt_reg <= CMD_I.d1;
    end
    else if (state_reg == ST_WTIME && pause_tick)
      pause_cnt_reg <= pause_cnt_reg - 16'h0001;
  end

  // ----------------------------------------------------------------
  // reply stream
  // ----------------------------------------------------------------
  // listing walks every item; a current query sends the one item only
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      dump_idx_reg <= 4'h0;
      dump_one_reg <= 1'b0;
      rpt_valid_reg <= 1'b0;
      rpt_reg <= '0;
    end
    else if (state_reg == ST_IDLE && state_next == ST_DUMP)
    begin
      rpt_valid_reg <= 1'b1;
      if (is_exam)
      begin
        dump_idx_reg <= 4'h0;
        dump_one_reg <= 1'b0;
        rpt_reg <= dump_item(4'h0);
      end
      else
      begin
        dump_idx_reg <= `WEC_IDX_CURRENT;
        dump_one_reg <= 1'b1;
        rpt_reg <= dump_item(`WEC_IDX_CURRENT);
      end
    end
    else if (state_reg == ST_DUMP && RPT_READY_I)
    begin
      if (state_next == ST_IDLE)
        rpt_valid_reg <= 1'b0;
      else
      begin
        dump_idx_reg <= dump_idx_reg + 4'h1;
        rpt_reg <= dump_item(dump_idx_reg + 4'h1);
      end
    end
  end

  // ----------------------------------------------------------------
  // drive current
  // ----------------------------------------------------------------
  // hold and run settings from the command or the register port
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      hold_reg <= `WEC_HOLD_DEF;
      run_reg <= `WEC_RUN_DEF;
    end
    else if (is_cur && CMD_I.has_d1)
    begin
      hold_reg <= pct_or_def(1'b1, CMD_I.d1, `WEC_HOLD_DEF);
      run_reg <= pct_or_def(CMD_I.has_d2, CMD_I.d2, `WEC_RUN_DEF);
    end
    else if (cur_wr)
    begin
      hold_reg <= pct_or_def(1'b1, {9'h000, WDATA_I[`WEC_CUR_HOLD_LSB +: 7]}, `WEC_HOLD_DEF);
      run_reg <= pct_or_def(1'b1, {9'h000, WDATA_I[`WEC_CUR_RUN_LSB +: 7]}, `WEC_RUN_DEF);
    end
  end

  // run phase lasts through motion and the settle count after it; the free running ms tick can cut its first ms short
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      run_phase_reg <= 1'b0;
      settle_cnt_reg <= 16'h0000;
    end
    else if (MOTION_BUSY_I)
    begin
      run_phase_reg <= 1'b1;
      settle_cnt_reg <= prm_reg[`WEC_IDX_SETTLE][15:0];
    end
    else if (run_phase_reg)
    begin
      if (settle_cnt_reg == 16'h0000)
        run_phase_reg <= 1'b0;
      else if (ms_tick_reg)
        settle_cnt_reg <= settle_cnt_reg - 16'h0001;
    end
  end

  // applied level; busy bypasses the phase flop so the switch is at once
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      drive_pct_reg <= `WEC_HOLD_DEF;
      drive_on_reg <= 1'b1;
    end
    else if (MOTION_BUSY_I || run_phase_reg)
    begin
      drive_pct_reg <= run_reg;
      drive_on_reg <= (run_reg != 7'h00);
    end
    else
    begin
      drive_pct_reg <= hold_reg;
      drive_on_reg <= (hold_reg != 7'h00);
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  // stored settings that the listing reports
  generate
    for (genvar i = 0; i < `WEC_NPARAM; i++)
    begin : g_prm
      always_ff @(posedge CLK_I or posedge RST_I)
      begin
        if (RST_I)
          prm_reg[i] <= `WEC_PARAM_RST;
        else if (WR_I && ADDR_I == 8'(`WEC_OFS_PARAM + 4 * i))
          prm_reg[i] <= WDATA_I;
      end
    end
  endgenerate

  // read data stands for the one cycle after the strobe only
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      rdata_reg <= 32'h0000_0000;
    else if (!RD_I)
      rdata_reg <= 32'h0000_0000;
    else if (ADDR_I == `WEC_OFS_STATUS)
      rdata_reg <= {16'h0000, 1'b0, drive_pct_reg, 4'h0, drive_on_reg, run_phase_reg,
                    state_reg};
    else if (ADDR_I == `WEC_OFS_CURRENT)
      rdata_reg <= {17'h00000, run_reg, 1'b0, hold_reg};
    else if (ADDR_I == `WEC_OFS_PAUSE)
      rdata_reg <= {16'h0000, pause_cnt_reg};
    else if (ADDR_I == `WEC_OFS_SETTLE)
      rdata_reg <= {16'h0000, settle_cnt_reg};
    else if (ADDR_I >= `WEC_OFS_PARAM && ADDR_I <= `WEC_OFS_PARAM_END && ADDR_I[1:0] == 2'b00)
      rdata_reg <= prm_reg[4'(ADDR_I[5:2])];
    else
      rdata_reg <= 32'h0000_0000; // unmapped reads as zero
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign RDATA_O = rdata_reg;
  assign CMD_READY_O = cmd_ready_reg;
  assign RPT_VALID_O = rpt_valid_reg;
  assign RPT_O = rpt_reg;
  assign DRIVE_PCT_O = drive_pct_reg;
  assign DRIVE_ON_O = drive_on_reg;
  assign RUN_PHASE_O = run_phase_reg;

endmodule // wec_core

// ==== tb/wec_core_sva.sv ====
// port assertions for the command block
`timescale 1ns/10ps
`include "wec_params.svh"
module wec_core_sva
  import wec_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic PROG_MODE_I,
  input wire logic MULTI_AXIS_I,
  input wire logic CMD_VALID_I,
  input wire wec_cmd_t CMD_I,
  input wire logic CMD_READY_O,
  input wire logic MOTION_BUSY_I,
  input wire logic RPT_VALID_O,
  input wire wec_rpt_t RPT_O,
  input wire logic RPT_READY_I,
  input wire logic [6:0] DRIVE_PCT_O,
  input wire logic DRIVE_ON_O,
  input wire logic RUN_PHASE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // a command is taken on this edge
  logic tk;
  assign tk = CMD_VALID_I && CMD_READY_O;

  // ----
  // assertions
  // ----
  a_pause_stalls_next: assert property (tk && PROG_MODE_I && CMD_I.letter == `WEC_LTR_PAUSE
    |=> !CMD_READY_O) else $error("pause did not stall");
  a_pause_imm_skip: assert property (tk && !PROG_MODE_I && CMD_I.letter == `WEC_LTR_PAUSE
    |=> CMD_READY_O) else $error("pause honoured in immediate mode");
  a_list_multi_none: assert property (tk && MULTI_AXIS_I && CMD_I.letter == `WEC_LTR_EXAM
    |=> !RPT_VALID_O) else $error("listing in multi-axis mode");
  a_list_first_item: assert property (tk && !PROG_MODE_I && !MULTI_AXIS_I
    && CMD_I.letter == `WEC_LTR_EXAM |=> RPT_VALID_O && RPT_O.letter == 8'h4B)
    else $error("listing does not open with ramp item");
  a_query_two_vals: assert property (tk && !PROG_MODE_I && CMD_I.letter == `WEC_LTR_CUR
    && !CMD_I.has_d1 |=> RPT_VALID_O && RPT_O.letter == `WEC_LTR_CUR && RPT_O.two)
    else $error("current query reply malformed");
  a_reply_item_holds: assert property (RPT_VALID_O && !RPT_READY_I
    |=> RPT_VALID_O && $stable(RPT_O)) else $error("reply item dropped or changed");
  a_run_on_motion: assert property (MOTION_BUSY_I |=> RUN_PHASE_O)
    else $error("run phase missing during motion");
  a_hold_after_rest: assert property ($fell(RUN_PHASE_O) |-> !$past(MOTION_BUSY_I))
    else $error("run phase ended while moving");
  a_off_at_zero: assert property (DRIVE_ON_O == (DRIVE_PCT_O != 7'h00))
    else $error("drive enable disagrees with percent");
  // main scenarios reached
  c_listing: cover property (tk && CMD_I.letter == `WEC_LTR_EXAM);
  c_pause: cover property (tk && PROG_MODE_I && CMD_I.letter == `WEC_LTR_PAUSE);
  c_settle_end: cover property ($fell(RUN_PHASE_O));
endmodule // wec_core_sva

bind wec_core wec_core_sva wec_core_sva_i (.CLK_I(CLK_I), .RST_I(RST_I),
  .PROG_MODE_I(PROG_MODE_I), .MULTI_AXIS_I(MULTI_AXIS_I), .CMD_VALID_I(CMD_VALID_I),
  .CMD_I(CMD_I), .CMD_READY_O(CMD_READY_O), .MOTION_BUSY_I(MOTION_BUSY_I),
  .RPT_VALID_O(RPT_VALID_O), .RPT_O(RPT_O), .RPT_READY_I(RPT_READY_I),
  .DRIVE_PCT_O(DRIVE_PCT_O), .DRIVE_ON_O(DRIVE_ON_O), .RUN_PHASE_O(RUN_PHASE_O));

// ==== tb/wec_host_model.sv ====
// host side model: takes reply items, promptly or slowly
`timescale 1ns/10ps
module wec_host_model
  import wec_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic SLOW_I,
  input wire logic RPT_VALID_I,
  input wire wec_rpt_t RPT_I,
  output logic RPT_READY_O
);
  wec_rpt_t got[$];
  // slow host toggles ready so items must wait
  always_ff @(posedge CLK_I or posedge RST_I)
    if (RST_I)
      RPT_READY_O <= 1'b0;
    else
      RPT_READY_O <= SLOW_I ? !RPT_READY_O : 1'b1;
  // keep every accepted item: letter echo then value
  always @(posedge CLK_I)
    if (!RST_I && RPT_VALID_I && RPT_READY_O)
      got.push_back(RPT_I);
endmodule // wec_host_model

// ==== tb/wec_core_tb_top.sv ====
// top testbench of the command block
`timescale 1ns/10ps
`include "wec_params.svh"
module wec_core_tb_top
  import wec_pkg::*;
;
  logic CLK_I = 1'b0;
  logic RST_I = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wr = 1'b0, rd = 1'b0, prog = 1'b0, multi = 1'b0, cvalid = 1'b0;
  logic busy = 1'b0, cmove = 1'b0, atspd = 1'b0, slow = 1'b0;
  logic cready, rvalid, rready, don, runph;
  logic [6:0] pct;
  wec_cmd_t cmd = '0;
  wec_rpt_t rpt;
  int fails = 0, n_checks = 0, cyc = 0, n, i;
  logic [7:0] lt [12] = '{8'h4B, 8'h49, 8'h42, 8'h56, 8'h59, 8'h45,
    8'h44, 8'h48, 8'h55, 8'h54, 8'h31, 8'h4E};

  // short counts keep the run brief
  wec_core #(.MS_CYCLES(10), .PAUSE_CYCLES(20)) wec_core_i (.CLK_I(CLK_I), .RST_I(RST_I),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .PROG_MODE_I(prog), .MULTI_AXIS_I(multi), .CMD_VALID_I(cvalid), .CMD_I(cmd),
    .CMD_READY_O(cready), .MOTION_BUSY_I(busy), .CONST_MOVE_I(cmove), .AT_SPEED_I(atspd),
    .RPT_VALID_O(rvalid), .RPT_O(rpt), .RPT_READY_I(rready), .DRIVE_PCT_O(pct),
    .DRIVE_ON_O(don), .RUN_PHASE_O(runph));
  wec_host_model wec_host_model_i (.CLK_I(CLK_I), .RST_I(RST_I), .SLOW_I(slow),
    .RPT_VALID_I(rvalid), .RPT_I(rpt), .RPT_READY_O(rready));

  // clock and hang guard
  always #50 CLK_I = !CLK_I;
  always @(posedge CLK_I)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      test_done;
    end
  end

  // ----
  // tasks
  // ----
  task chk(input logic [47:0] g, input logic [47:0] e);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_I);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge CLK_I);
    wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge CLK_I);
    addr <= a;
    rd <= 1'b1;
    @(posedge CLK_I);
    rd <= 1'b0;
    @(negedge CLK_I);
    chk(rdata, e);
  endtask
  task send(input logic [7:0] l, input logic h1, input logic [15:0] d1, input logic [15:0] d2);
    @(posedge CLK_I);
    cmd <= '{l, h1, h1, d1, d2};
    cvalid <= 1'b1;
    @(negedge CLK_I);
    while (cready !== 1'b1)
      @(negedge CLK_I);
    @(posedge CLK_I);
    cvalid <= 1'b0;
  endtask
  task low_len;
    n = 0;
    @(negedge CLK_I);
    while (cready !== 1'b1 && n < 5000)
    begin
      @(negedge CLK_I);
      n++;
    end
  endtask
  task set_busy(input logic b);
    @(posedge CLK_I);
    busy <= b;
  endtask
  task test_done;
    $display("checks %0d errors %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----
  // main sequence
  // ----
  initial
  begin
    repeat (8) @(posedge CLK_I);
    RST_I <= 1'b0;
    rd_reg(8'h04, 32'h3219);
    chk(pct, 7'h19);
    rd_reg(8'h00, 32'h0000_1908);
    rd_reg(8'hFC, 32'h0);
    wr_reg(8'h04, 32'h500A);
    repeat (2) @(negedge CLK_I);
    chk(pct, 7'h0A);
    wr_reg(8'h04, 32'h5065);
    rd_reg(8'h04, 32'h5019);
    wr_reg(8'h04, 32'h6464);
    rd_reg(8'h04, 32'h6464);
    wr_reg(8'h04, 32'h5000);
    repeat (2) @(negedge CLK_I);
    chk(don, 1'b0);
    wr_reg(8'h54, 32'h3);
    wr_reg(8'h40, 32'h0003_0005);
    // motion raises run current at once, settle then drops it
    set_busy(1'b1);
    repeat (2) @(negedge CLK_I);
    chk({runph, pct}, {1'b1, 7'h50});
    rd_reg(8'h0C, 32'h3);
    set_busy(1'b0);
    repeat (15) @(negedge CLK_I);
    chk(runph, 1'b1);
    repeat (30) @(negedge CLK_I);
    chk({runph, don, pct}, 9'h0);
    // current query and setting, host stalling
    @(posedge CLK_I);
    slow <= 1'b1;
    send(8'h59, 1'b0, 16'h0, 16'h0);
    send(8'h59, 1'b1, 16'h000A, 16'h0050);
    repeat (2) @(negedge CLK_I);
    chk(pct, 7'h0A);
    send(8'h59, 1'b0, 16'h0, 16'h0);
    send(8'h58, 1'b0, 16'h0, 16'h0);
    n = 0;
    while (wec_host_model_i.got.size() < 14 && n < 300)
    begin
      @(negedge CLK_I);
      n++;
    end
    chk(wec_host_model_i.got[0], {7'h00, 8'h59, 1'b1, 32'h0000_0050});
    chk(wec_host_model_i.got[1], {7'h00, 8'h59, 1'b1, 32'h000A_0050});
    for (i = 0; i < 12; i++)
      chk(wec_host_model_i.got[2 + i].letter, lt[i]);
    chk(wec_host_model_i.got[2].val_a, 16'h0005);
    chk(wec_host_model_i.got[7].val_a, 16'h0003);
    // multi-axis: no listing, single query still answered
    @(posedge CLK_I);
    multi <= 1'b1;
    send(8'h58, 1'b0, 16'h0, 16'h0);
    send(8'h59, 1'b0, 16'h0, 16'h0);
    repeat (8) @(negedge CLK_I);
    chk(wec_host_model_i.got.size(), 15);
    chk(wec_host_model_i.got[14].letter, 8'h59);
    @(posedge CLK_I);
    multi <= 1'b0;
    slow <= 1'b0;
    send(8'h57, 1'b1, 16'h0005, 16'h0);
    @(negedge CLK_I);
    chk(cready, 1'b1);
    // timed pause starts with motion and ignores it
    @(posedge CLK_I);
    prog <= 1'b1;
    set_busy(1'b1);
    send(8'h57, 1'b1, 16'h0002, 16'h0);
    rd_reg(8'h08, 32'h2);
    low_len;
    chk(n >= 34 && n <= 40, 1'b1);
    // zero pause and bare pause wait for motion end
    send(8'h57, 1'b1, 16'h0, 16'h0);
    repeat (10) @(negedge CLK_I);
    chk(cready, 1'b0);
    set_busy(1'b0);
    low_len;
    chk(n <= 3, 1'b1);
    set_busy(1'b1);
    send(8'h57, 1'b0, 16'h0, 16'h0);
    repeat (5) @(negedge CLK_I);
    chk(cready, 1'b0);
    set_busy(1'b0);
    low_len;
    chk(n <= 3, 1'b1);
    // constant-velocity move releases at target speed
    @(posedge CLK_I);
    cmove <= 1'b1;
    set_busy(1'b1);
    send(8'h57, 1'b1, 16'h0, 16'h0);
    repeat (5) @(negedge CLK_I);
    chk(cready, 1'b0);
    @(posedge CLK_I);
    atspd <= 1'b1;
    low_len;
    chk({n <= 3, busy}, 2'b11);
    // listing and current query stay silent in program mode
    send(8'h58, 1'b0, 16'h0, 16'h0);
    send(8'h59, 1'b0, 16'h0, 16'h0);
    repeat (4) @(negedge CLK_I);
    chk(wec_host_model_i.got.size(), 15);
    test_done;
  end
endmodule // wec_core_tb_top
